// ===== verilog/xpt_pkg.sv
// Package: constants, register map and types for the input monitor and crosspoint
package xpt_pkg;
  localparam int NUM_IN = 4;
  localparam int NUM_OUT_MAX = 4;
  localparam int SEL_W = 2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] REG_XPT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'hc;
  // Interrupt mask sits in the upper half of the address range
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h0;
  localparam logic REG_HI_MASK = 1'b1;

  // Control register field positions
  localparam int CTRL_BYPASS_LSB = 0;
  localparam int CTRL_MUTE_EN_LSB = 4;
  localparam int CTRL_OUT_DIS_LSB = 8;

  // Values after reset: bypass off, automute on, outputs enabled, straight routing
  localparam logic [NUM_IN-1:0] BYPASS_RST = 4'h0;
  localparam logic [NUM_IN-1:0] MUTE_EN_RST = 4'hf;
  localparam logic [NUM_OUT_MAX-1:0] OUT_DIS_RST = 4'h0;
  localparam logic [7:0] XPT_RST = 8'he4;

  // Rate classes reported per input
  typedef enum logic [2:0] {
    RATE_NONE = 3'h0,
    RATE_SD = 3'h1,
    RATE_HD = 3'h2,
    RATE_3G = 3'h3,
    RATE_VALID = 3'h4
  } rate_t;

  // Supported bit-rate span of the equalizer/reclocker path, in kbit/s
  localparam int RATE_MIN_KBPS = 19000;
  localparam int RATE_MAX_KBPS = 3000000;

  // Status word layout per input: active, locked, rate (3 bits), spare
  localparam int STAT_FIELD_W = 8;
  localparam int IRQ_EVENTS = 2 * NUM_IN;
endpackage : xpt_pkg

// ===== verilog/input_classifier.sv
// One input's status classifier and reclock/automute path
`timescale 1ns/1ps
module input_classifier (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic sig_present_in,
  input wire logic levels_ok_in,
  input wire logic [1:0] std_rate_in,
  input wire logic std_valid_in,
  input wire logic raw_data_in,
  input wire logic reclk_data_in,
  input wire logic bypass_in,
  input wire logic mute_en_in,
  output logic active_out,
  output logic locked_out,
  output xpt_pkg::rate_t rate_out,
  output logic data_out
);
  import xpt_pkg::*;

  // Pin-side status passes two flops before use
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  wire active_w = s2_q[0] & s2_q[1];
  wire std_w = active_w & s2_q[4];
  rate_t rate_w;

  always_comb begin
    if (!active_w) begin
      rate_w = RATE_NONE;
    end else if (!std_w) begin
      rate_w = RATE_VALID;
    end else begin
      case (s2_q[3:2])
        2'h0: rate_w = RATE_SD;
        2'h1: rate_w = RATE_HD;
        default: rate_w = RATE_3G;
      endcase
    end
  end

  // Reclocker ahead of automute; automute blanks while not locked
  wire path_w = bypass_in ? raw_data_in : reclk_data_in;
  wire mute_w = mute_en_in & ~std_w;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      active_out <= 1'b0;
      locked_out <= 1'b0;
      rate_out <= RATE_NONE;
      data_out <= 1'b0;
    end else begin
      s1_q <= {std_valid_in, std_rate_in, levels_ok_in, sig_present_in};
      s2_q <= s1_q;
      active_out <= active_w; // [R1]
      rate_out <= rate_w; // [R2]
      locked_out <= std_w; // [R3]
      data_out <= mute_w ? 1'b0 : path_w; // [R5] [R6]
    end
  end
endmodule : input_classifier

// ===== verilog/output_channel.sv
// One fibre output: source select and laser driver enable
`timescale 1ns/1ps
module output_channel (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] in_data_in,
  input wire logic [1:0] sel_in,
  input wire logic dis_in,
  output logic data_out,
  output logic laser_en_out
);
  import xpt_pkg::*;

  wire pick_w = in_data_in[sel_in];

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_out <= 1'b0;
      laser_en_out <= 1'b0;
    end else begin
      data_out <= dis_in ? 1'b0 : pick_w; // [R9] [R10]
      laser_en_out <= ~dis_in; // [R11]
    end
  end
endmodule : output_channel

// ===== verilog/sdi_input_monitor_crosspoint.sv
// Top: four-input status monitor, reclock/automute paths and crosspoint
`timescale 1ns/1ps
//
// Operation
// R1 - Input reports active for any valid signal, inactive when absent or bad levels.
// R2 - Input reports standard rate class, or generic valid when rate unrecognised.
// R3 - Locked shown for standard rate; unlocked flag for usable non-standard signal.
// R4 - Equalize/reclock path covers the stated low to high bit rates.
// R5 - Reclock precedes automute; automute blanks while reclocker is unlocked.
// R6 - Each input has its own reclock bypass and automute disable.
// R7 - Default: bypass off and automute on for every input.
// R8 - Software should bypass and unmute inputs carrying non-standard signals.
// R9 - Each fitted output selects any of the four inputs.
// R10 - One input may feed several outputs at once.
// R11 - Output disable switches its laser driver off.
// R12 - Controls exist only for fitted output channels.
// R13 - Changing one channel's setting leaves the others undisturbed.
//
module sdi_input_monitor_crosspoint #(
  parameter int NUM_OUT = 4
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [xpt_pkg::ADDR_W:0] addr_in,
  input wire logic [xpt_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [xpt_pkg::DATA_W-1:0] rdata_out,
  output logic irq_out,
  input wire logic [xpt_pkg::NUM_IN-1:0] sig_present_in,
  input wire logic [xpt_pkg::NUM_IN-1:0] levels_ok_in,
  input wire logic [7:0] std_rate_in,
  input wire logic [xpt_pkg::NUM_IN-1:0] std_valid_in,
  input wire logic [xpt_pkg::NUM_IN-1:0] raw_data_in,
  input wire logic [xpt_pkg::NUM_IN-1:0] reclk_data_in,
  output logic [xpt_pkg::NUM_IN-1:0] reclk_bypass_out,
  output logic [xpt_pkg::NUM_OUT_MAX-1:0] fibre_data_out,
  output logic [xpt_pkg::NUM_OUT_MAX-1:0] laser_en_out
);
  import xpt_pkg::*;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [NUM_IN-1:0] bypass_q;
  logic [NUM_IN-1:0] mute_en_q;
  logic [NUM_OUT_MAX-1:0] out_dis_q;
  logic [7:0] xpt_q;
  logic [IRQ_EVENTS-1:0] irq_stat_q;
  logic [IRQ_EVENTS-1:0] irq_mask_q;

  // Only fitted outputs carry controls; unfitted ones stay disabled
  function automatic logic [NUM_OUT_MAX-1:0] fitted_mask(input int n);
    logic [NUM_OUT_MAX-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_OUT_MAX; i++) begin
      if (i < n) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : fitted_mask

  localparam logic [NUM_OUT_MAX-1:0] FIT_W = fitted_mask(NUM_OUT);
  localparam logic [7:0] XPT_FIT = {{2{FIT_W[3]}}, {2{FIT_W[2]}}, {2{FIT_W[1]}}, {2{FIT_W[0]}}};

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire hi_w = addr_in[ADDR_W];
  wire [ADDR_W-1:0] off_w = addr_in[ADDR_W-1:0];
  wire wr_ctrl_w = wr_in & ~hi_w & (off_w == REG_CTRL);
  wire wr_xpt_w = wr_in & ~hi_w & (off_w == REG_XPT);
  wire wr_istat_w = wr_in & ~hi_w & (off_w == REG_IRQ_STAT);
  wire wr_imask_w = wr_in & (hi_w == REG_HI_MASK) & (off_w == REG_IRQ_MASK);

  // ----------------------------------------
  // Input paths
  // ----------------------------------------
  logic [NUM_IN-1:0] active_w;
  logic [NUM_IN-1:0] locked_w;
  rate_t rate_w [NUM_IN];
  logic [NUM_IN-1:0] path_w;

  for (genvar g = 0; g < NUM_IN; g++) begin : g_in
    input_classifier u_cls (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .sig_present_in(sig_present_in[g]),
      .levels_ok_in(levels_ok_in[g]),
      .std_rate_in(std_rate_in[2*g+:2]),
      .std_valid_in(std_valid_in[g]),
      .raw_data_in(raw_data_in[g]),
      .reclk_data_in(reclk_data_in[g]),
      .bypass_in(bypass_q[g]),
      .mute_en_in(mute_en_q[g]),
      .active_out(active_w[g]),
      .locked_out(locked_w[g]),
      .rate_out(rate_w[g]),
      .data_out(path_w[g])
    ); // [R4] [R13]
  end

  // ----------------------------------------
  // Crosspoint
  // ----------------------------------------
  for (genvar o = 0; o < NUM_OUT_MAX; o++) begin : g_out
    output_channel u_out (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .in_data_in(path_w),
      .sel_in(xpt_q[2*o+:2]),
      .dis_in(out_dis_q[o] | ~FIT_W[o]),
      .data_out(fibre_data_out[o]),
      .laser_en_out(laser_en_out[o])
    ); // [R9] [R10] [R12] [R13]
  end

  // ----------------------------------------
  // Events: lock gained or lost, activity gained or lost
  // ----------------------------------------
  logic [NUM_IN-1:0] active_d1_q;
  logic [NUM_IN-1:0] locked_d1_q;
  wire [IRQ_EVENTS-1:0] event_w = {locked_w ^ locked_d1_q, active_w ^ active_d1_q};
  wire [IRQ_EVENTS-1:0] clr_w = wr_istat_w ? wdata_in[IRQ_EVENTS-1:0] : '0;
  // Set wins over a clear in the same cycle
  wire [IRQ_EVENTS-1:0] irq_stat_d = (irq_stat_q & ~clr_w) | event_w;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [DATA_W-1:0] stat_word_w;
  always_comb begin
    stat_word_w = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      stat_word_w[i*STAT_FIELD_W+:STAT_FIELD_W] = {3'h0, rate_w[i], locked_w[i], active_w[i]}; // [R1] [R2] [R3]
    end
  end

  wire [DATA_W-1:0] ctrl_word_w = {20'h0, out_dis_q, mute_en_q, bypass_q};
  wire [DATA_W-1:0] xpt_word_w = {24'h0, xpt_q};
  wire [DATA_W-1:0] istat_word_w = {24'h0, irq_stat_q};
  wire [DATA_W-1:0] imask_word_w = {24'h0, irq_mask_q};
  wire [DATA_W-1:0] rdata_d =
    hi_w ? ((off_w == REG_IRQ_MASK) ? imask_word_w : '0) :
    (off_w == REG_STATUS) ? stat_word_w :
    (off_w == REG_CTRL) ? ctrl_word_w :
    (off_w == REG_XPT) ? xpt_word_w :
    (off_w == REG_IRQ_STAT) ? istat_word_w : '0;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bypass_q <= BYPASS_RST; // [R7]
      mute_en_q <= MUTE_EN_RST; // [R7]
      out_dis_q <= OUT_DIS_RST;
      xpt_q <= XPT_RST;
    end else begin
      if (wr_ctrl_w) begin
        bypass_q <= wdata_in[CTRL_BYPASS_LSB+:NUM_IN]; // [R6] [R8]
        mute_en_q <= wdata_in[CTRL_MUTE_EN_LSB+:NUM_IN]; // [R6]
        out_dis_q <= wdata_in[CTRL_OUT_DIS_LSB+:NUM_OUT_MAX] & FIT_W; // [R11] [R12]
      end
      if (wr_xpt_w) begin
        // Unfitted selectors keep their value so they cannot be steered
        xpt_q <= (wdata_in[7:0] & XPT_FIT) | (xpt_q & ~XPT_FIT); // [R9] [R12] [R13]
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_d1_q <= '0;
      locked_d1_q <= '0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_out <= 1'b0;
      rdata_out <= '0;
      reclk_bypass_out <= BYPASS_RST;
    end else begin
      active_d1_q <= active_w;
      locked_d1_q <= locked_w;
      irq_stat_q <= irq_stat_d;
      if (wr_imask_w) begin
        irq_mask_q <= wdata_in[IRQ_EVENTS-1:0];
      end
      irq_out <= |(irq_stat_d & irq_mask_q);
      rdata_out <= rd_in ? rdata_d : '0;
      reclk_bypass_out <= bypass_q; // [R6]
    end
  end
endmodule : sdi_input_monitor_crosspoint

// ===== testbench/sdi_input_monitor_crosspoint_sva.sv
// Checker: port-level assertions for the input monitor and crosspoint
`timescale 1ns/1ps
module sdi_input_monitor_crosspoint_sva #(
  parameter int NUM_OUT = 4
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [4:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [3:0] reclk_bypass_out,
  input wire logic [3:0] fibre_data_out,
  input wire logic [3:0] laser_en_out
);
  localparam logic [3:0] FIT = 4'((1 << NUM_OUT) - 1);
  wire ctrl_wr = wr_in && addr_in == 5'h04;
  wire ctrl_rd = rd_in && addr_in == 5'h04;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0) else $error("read data outside slot");
  a_unfitted_dark: assert property ((laser_en_out & ~FIT) == 4'h0) else $error("unfitted laser on");
  a_fibre_dark: assert property ((fibre_data_out & ~laser_en_out & ~$past(laser_en_out)) == 4'h0)
    else $error("data on disabled output");
  // Control writes land in a register, then the pins follow one edge later
  a_bypass_write: assert property (ctrl_wr |=> ##1 reclk_bypass_out == $past(wdata_in[3:0], 2))
    else $error("bypass not applied");
  a_laser_write: assert property (ctrl_wr |=> ##1 laser_en_out == (~$past(wdata_in[11:8], 2) & FIT))
    else $error("laser enable not applied");
  a_bypass_hold: assert property (!ctrl_wr && !$past(ctrl_wr) |=> $stable(reclk_bypass_out))
    else $error("bypass moved");
  a_laser_hold: assert property ($past(rst_b_in, 2) && !ctrl_wr && !$past(ctrl_wr) |=> $stable(laser_en_out))
    else $error("laser enable moved");
  a_unmapped_read: assert property (rd_in && addr_in == 5'h14 |=> rdata_out == 32'h0) else $error("unmapped read");
  a_ctrl_readback: assert property (ctrl_rd |=> rdata_out[3:0] == $past(reclk_bypass_out) &&
    rdata_out[11:8] == (~$past(laser_en_out) & FIT)) else $error("control readback mismatch");
  c_ctrl_write: cover property (ctrl_wr);
  c_laser_off: cover property ((laser_en_out ^ FIT) != 4'h0);
  c_status_read: cover property (rd_in && addr_in == 5'h00);
endmodule : sdi_input_monitor_crosspoint_sva
bind sdi_input_monitor_crosspoint sdi_input_monitor_crosspoint_sva #(.NUM_OUT(NUM_OUT)) u_sva (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .reclk_bypass_out(reclk_bypass_out),
  .fibre_data_out(fibre_data_out), .laser_en_out(laser_en_out));

// ===== testbench/video_source_model.sv
// Partner: four serial video sources with distinct slow patterns
`timescale 1ns/1ps
module video_source_model (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  output logic [3:0] raw_data_out,
  output logic [3:0] reclk_data_out,
  output logic settled_out
);
  logic [7:0] cnt_q;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) cnt_q <= 8'h0;
    else cnt_q <= cnt_q + 8'h1;
  end
  // Raw is the inverse of reclocked so a bypass shows as a flipped stream
  assign reclk_data_out = cnt_q[6:3];
  assign raw_data_out = ~cnt_q[6:3];
  // High once data has held four cycles, hiding pipeline latency
  assign settled_out = cnt_q[2];
endmodule : video_source_model

// ===== testbench/tb_sdi_input_monitor_crosspoint.sv
// Testbench: register, status, interrupt and crosspoint checks
`timescale 1ns/1ps
module tb_sdi_input_monitor_crosspoint;
  import xpt_pkg::*;
  logic mclk_in = 0, rst_b_in = 0, wr_s = 0, rd_s = 0;
  logic [4:0] addr = 5'h0;
  logic [31:0] wdata = 32'h0, v;
  logic [3:0] present = 4'h0, lvl_ok = 4'h0, valid = 4'h0;
  logic [7:0] rate_code = 8'h0;
  logic [2:0] rt_tab [4] = '{3'h1, 3'h2, 3'h3, 3'h3};
  wire [3:0] raw, reclk, bypass, fibre, laser;
  wire [31:0] rdata;
  wire settled, irq;
  int failures = 0, n_checks = 0, cycles = 0;
  always #2.5 mclk_in = ~mclk_in;
  video_source_model u_src (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .raw_data_out(raw),
    .reclk_data_out(reclk), .settled_out(settled));
  sdi_input_monitor_crosspoint #(.NUM_OUT(3)) u_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .irq_out(irq), .sig_present_in(present),
    .levels_ok_in(lvl_ok), .std_rate_in(rate_code), .std_valid_in(valid), .raw_data_in(raw),
    .reclk_data_in(reclk), .reclk_bypass_out(bypass), .fibre_data_out(fibre), .laser_en_out(laser));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge mclk_in);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr <= a; rd_s <= 1'b1;
    @(posedge mclk_in);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Expected fibre word from routing, bypass and which outputs should carry data
  task automatic path(input logic [7:0] sel, input logic [3:0] byp, input logic [3:0] on);
    logic [3:0] e;
    // A new routing reaches the fibre pins one edge after the write lands, a new bypass two edges after
    repeat (2) @(posedge mclk_in);
    repeat (40) begin
      @(negedge mclk_in);
      if (settled) begin
        for (int o = 0; o < 4; o++) e[o] = on[o] & (byp[sel[2*o+:2]] ? raw[sel[2*o+:2]] : reclk[sel[2*o+:2]]);
        chk("fibre", {28'h0, e}, {28'h0, fibre});
      end
    end
  endtask : path
  task automatic final_report;
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rd(5'h04, v); chk("ctrl", 32'h0f0, v);
    rd(5'h08, v); chk("xpt", 32'h24, v & 32'h3f);
    rd(5'h10, v); chk("mask", 32'h0, v);
    wr(5'h14, 32'hffffffff); rd(5'h14, v); chk("unmapped", 32'h0, v);
    @(posedge mclk_in);
    present <= 4'b1011; lvl_ok <= 4'b0011; valid <= 4'b0001;
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk_in);
      rate_code <= 8'(r);
      repeat (6) @(posedge mclk_in);
      rd(5'h00, v); chk("status", {16'h0, 8'h11, 3'h0, rt_tab[r], 2'b11}, v);
    end
    rd(5'h0c, v); chk("irq_stat", 32'h13, v);
    @(negedge mclk_in); chk("irq", 32'h0, {31'h0, irq});
    wr(5'h10, 32'h10); repeat (3) @(negedge mclk_in); chk("irq", 32'h1, {31'h0, irq});
    wr(5'h0c, 32'h13); repeat (3) @(negedge mclk_in); chk("irq", 32'h0, {31'h0, irq});
    rd(5'h0c, v); chk("irq_stat", 32'h0, v);
    wr(5'h08, 32'hc5); path(8'hc5, 4'h0, 4'b0100);
    wr(5'h04, 32'h0d2); path(8'hc5, 4'h2, 4'b0111);
    chk("bypass", 32'h2, {28'h0, bypass});
    wr(5'h04, 32'had2); repeat (2) @(negedge mclk_in); chk("laser", 32'h5, {28'h0, laser});
    path(8'hc5, 4'h2, 4'b0101);
    rd(5'h04, v); chk("ctrl", 32'h2d2, v);
    final_report();
  end
endmodule : tb_sdi_input_monitor_crosspoint
